// ---- ledpwm_pkg.sv ----
`default_nettype none
package ledpwm_pkg;

    // Clock period of the single system clock (20 MHz)
    localparam int CLK_PERIOD_NS = 50;

    // Register indices; byte address is four times the index
    localparam logic [7:0] IDX_MODE_CONFIG_TWO = 8'h01;
    localparam logic [7:0] IDX_CHANNEL_DUTY0 = 8'h02;
    localparam logic [7:0] IDX_GROUP_DUTY = 8'h06;
    localparam logic [7:0] IDX_GROUP_PERIOD = 8'h07;
    localparam logic [7:0] IDX_LED_STATE_SELECT = 8'h08;
    localparam logic [7:0] IDX_OUTPUT_STATUS = 8'h0D;
    localparam int NUM_CHANNELS = 4;

    // Field positions in mode_config_two
    localparam int BIT_DRIVE_TYPE = 0;
    localparam int BIT_INVERT = 1;
    localparam int BIT_DIM_BLINK = 2;
    localparam logic [7:0] MODE_WRITE_MASK = 8'h07;

    // Reset values
    localparam logic [7:0] RST_MODE_CONFIG_TWO = 8'h00;
    localparam logic [7:0] RST_CHANNEL_DUTY = 8'h00;
    localparam logic [7:0] RST_GROUP_DUTY = 8'h00;
    localparam logic [7:0] RST_GROUP_PERIOD = 8'h00;
    localparam logic [7:0] RST_LED_STATE_SELECT = 8'h00;

    // Channel state field encodings
    localparam logic [1:0] ST_OFF = 2'h0;
    localparam logic [1:0] ST_ON = 2'h1;
    localparam logic [1:0] ST_INDIV = 2'h2;
    localparam logic [1:0] ST_GROUP = 2'h3;

    // Individual PWM period 640 us (1.5625 kHz), 256 steps per period
    localparam int IND_PWM_PERIOD_NS = 640000;
    localparam int IND_STEPS = 256;
    localparam int IND_TICK_CYCLES = IND_PWM_PERIOD_NS / (CLK_PERIOD_NS * IND_STEPS);

    // Group dimming period 1/190 Hz, 16 steps per period
    localparam int DIM_PERIOD_NS = 5263157;
    localparam int DIM_STEPS = 16;
    localparam int DIM_TICK_CYCLES = DIM_PERIOD_NS / (CLK_PERIOD_NS * DIM_STEPS);

    // Blink base period 1/24 s, times (code + 1), 256 steps per period
    localparam int BLINK_UNIT_NS = 41666666;
    localparam int BLINK_STEPS = 256;
    localparam int BLINK_UNIT_CYCLES = BLINK_UNIT_NS / (CLK_PERIOD_NS * BLINK_STEPS);

    // Codes up to this value blink at 6 Hz or faster
    localparam logic [7:0] FAST_BLINK_MAX_CODE = 8'h03;

endpackage : ledpwm_pkg
`default_nettype wire

// ---- ledpwm_top.sv ----
// What this block does
// [RQ1] Per-channel 8-bit PWM at 1.5625 kHz
// [RQ2] Shared 190 Hz dimming with 16 steps
// [RQ3] Shared blink, 8-bit period, 64/256 duty steps
// [RQ4] One group signal, dim or blink, shared
// [RQ5] State 10 follows individual PWM only
// [RQ6] Dimming: 6.25 kHz 64-step PWM plus dimmer
// [RQ7] Fast blink uses 64-step group duty
// [RQ8] Slow blink uses 256-step group duty
// [RQ9] Invert bit complements state and PWM sense
// [RQ10] Drive bit zero keeps upper transistor off
// [RQ11] Off state transistor mapping by invert/drive
// [RQ12] On state transistor mapping by invert/drive
// [RQ13] Open-drain PWM switches lower transistor only
// [RQ14] Totem-pole PWM drives transistors complementarily
// [RQ15] Controller picks invert=1 drive=1 for N-type
// [RQ16] Controller picks invert=0 drive=1 for P-type
// [RQ17] Controller keeps invert=0 for direct LEDs
// [RQ18] State codes: off, on, PWM, PWM+group
// [RQ19] Blink period is (code+1)/24 seconds
// [RQ20] Period code ignored while dimming
// [RQ21] Slow blink duty is code over 256
// [RQ22] Group state ANDs individual and group
// [RQ23] All counters share one clock base
//
// Design decisions made here: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
`default_nettype none

module ledpwm_top #(
    // Dimmer step length in cycles; shorten for simulation
    parameter int DIM_TICK = ledpwm_pkg::DIM_TICK_CYCLES
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // LED pins: level, active-low output enable
    output logic [3:0] led_output_pin,
    output logic [3:0] led_output_pin_oe_n
);

    // Software-visible registers
    logic [7:0] mode_config_two;
    logic [7:0] channel_duty [4];
    logic [7:0] group_duty;
    logic [7:0] group_period;
    logic [7:0] led_state_select;
    logic [7:0] next_mode_config_two;
    logic [7:0] next_channel_duty [4];
    logic [7:0] next_group_duty;
    logic [7:0] next_group_period;
    logic [7:0] next_led_state_select;
    // Registered bus answers
    logic [31:0] next_prdata;
    logic next_pslverr;

    // Timebase counters
    logic [7:0] ind_div;
    logic [7:0] ind_cnt;
    logic [15:0] dim_div;
    logic [3:0] dim_cnt;
    logic [11:0] blink_div;
    logic [7:0] blink_mul;
    logic [7:0] blink_cnt;
    logic [7:0] next_ind_div;
    logic [7:0] next_ind_cnt;
    logic [15:0] next_dim_div;
    logic [3:0] next_dim_cnt;
    logic [11:0] next_blink_div;
    logic [7:0] next_blink_mul;
    logic [7:0] next_blink_cnt;

    // Pin stage
    logic [3:0] next_led_output_pin;
    logic [3:0] next_led_output_pin_oe_n;

    // Register index decoded from the byte address
    logic [7:0] reg_idx;
    logic addr_ok;
    logic idx_mapped;

    // Mode bits
    logic dim_blink_select;
    logic output_invert;
    logic output_drive_type;
    logic group_active;

    // Duty compare: counter below duty means active
    function automatic logic duty_hit(input logic [7:0] cnt, input logic [7:0] duty);
        duty_hit = (cnt < duty);
    endfunction : duty_hit

    assign reg_idx = paddr[9:2];
    assign addr_ok = (paddr[1:0] == 2'h0) && (paddr[31:10] == 22'h0);
    assign idx_mapped = addr_ok && (reg_idx == ledpwm_pkg::IDX_MODE_CONFIG_TWO ||
        (reg_idx >= ledpwm_pkg::IDX_CHANNEL_DUTY0 && reg_idx <= ledpwm_pkg::IDX_LED_STATE_SELECT) ||
        reg_idx == ledpwm_pkg::IDX_OUTPUT_STATUS);
    assign dim_blink_select = mode_config_two[ledpwm_pkg::BIT_DIM_BLINK];
    assign output_invert = mode_config_two[ledpwm_pkg::BIT_INVERT];
    assign output_drive_type = mode_config_two[ledpwm_pkg::BIT_DRIVE_TYPE];

    // Zero wait states: answer data is captured in the setup cycle
    assign pready = 1'b1;

    // Register writes in the access phase, read data captured in setup
    always_comb begin
        next_mode_config_two = mode_config_two;
        next_group_duty = group_duty;
        next_group_period = group_period;
        next_led_state_select = led_state_select;
        for (int i = 0; i < 4; i++) begin
            next_channel_duty[i] = channel_duty[i];
        end
        next_prdata = prdata;
        next_pslverr = pslverr;
        if (psel && !penable) begin
            // Setup: prepare the answer for the access cycle
            next_pslverr = !idx_mapped;
            next_prdata = 32'h0000_0000;
            if (idx_mapped && !pwrite) begin
                case (reg_idx)
                    ledpwm_pkg::IDX_MODE_CONFIG_TWO: next_prdata[7:0] = mode_config_two;
                    ledpwm_pkg::IDX_GROUP_DUTY: next_prdata[7:0] = group_duty;
                    ledpwm_pkg::IDX_GROUP_PERIOD: next_prdata[7:0] = group_period;
                    ledpwm_pkg::IDX_LED_STATE_SELECT: next_prdata[7:0] = led_state_select;
                    ledpwm_pkg::IDX_OUTPUT_STATUS: next_prdata[7:0] = {led_output_pin_oe_n, led_output_pin};
                    default: next_prdata[7:0] = channel_duty[2'(reg_idx - ledpwm_pkg::IDX_CHANNEL_DUTY0)];
                endcase
            end
        end else if (psel && penable && pwrite && idx_mapped) begin
            // Access: write takes effect; status register is read-only
            case (reg_idx)
                ledpwm_pkg::IDX_MODE_CONFIG_TWO: next_mode_config_two = pwdata[7:0] & ledpwm_pkg::MODE_WRITE_MASK;
                ledpwm_pkg::IDX_GROUP_DUTY: next_group_duty = pwdata[7:0];
                ledpwm_pkg::IDX_GROUP_PERIOD: next_group_period = pwdata[7:0];
                ledpwm_pkg::IDX_LED_STATE_SELECT: next_led_state_select = pwdata[7:0];
                ledpwm_pkg::IDX_OUTPUT_STATUS: next_group_duty = group_duty;
                default: next_channel_duty[2'(reg_idx - ledpwm_pkg::IDX_CHANNEL_DUTY0)] = pwdata[7:0];
            endcase
        end
    end

    // Register file and bus answer flops
    always_ff @(posedge clk) begin
        if (rst) begin
            // [RQ18] Channels start off
            mode_config_two <= ledpwm_pkg::RST_MODE_CONFIG_TWO;
            group_duty <= ledpwm_pkg::RST_GROUP_DUTY;
            group_period <= ledpwm_pkg::RST_GROUP_PERIOD;
            led_state_select <= ledpwm_pkg::RST_LED_STATE_SELECT;
            for (int i = 0; i < 4; i++) begin
                channel_duty[i] <= ledpwm_pkg::RST_CHANNEL_DUTY;
            end
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else begin
            mode_config_two <= next_mode_config_two;
            group_duty <= next_group_duty;
            group_period <= next_group_period;
            led_state_select <= next_led_state_select;
            for (int i = 0; i < 4; i++) begin
                channel_duty[i] <= next_channel_duty[i];
            end
            prdata <= next_prdata;
            pslverr <= next_pslverr;
        end
    end

    // Timebases: all run from clk, so channels keep a common phase
    always_comb begin
        next_ind_div = ind_div;
        next_ind_cnt = ind_cnt;
        next_dim_div = dim_div;
        next_dim_cnt = dim_cnt;
        next_blink_div = blink_div;
        next_blink_mul = blink_mul;
        next_blink_cnt = blink_cnt;
        // [RQ23] Shared step tick
        // [RQ1] 256 steps per 1.5625 kHz period
        if (ind_div == 8'(ledpwm_pkg::IND_TICK_CYCLES - 1)) begin
            next_ind_div = 8'h00;
            next_ind_cnt = ind_cnt + 8'h01;
        end else begin
            next_ind_div = ind_div + 8'h01;
        end
        // [RQ2] 16 steps per 190 Hz period
        if (dim_div >= 16'(DIM_TICK - 1)) begin
            next_dim_div = 16'h0000;
            next_dim_cnt = dim_cnt + 4'h1;
        end else begin
            next_dim_div = dim_div + 16'h0001;
        end
        // [RQ3] Programmable blink timebase
        // [RQ19] Step length (code+1) units, 256 steps
        if (blink_div == 12'(ledpwm_pkg::BLINK_UNIT_CYCLES - 1)) begin
            next_blink_div = 12'h000;
            if (blink_mul >= group_period) begin
                next_blink_mul = 8'h00;
                next_blink_cnt = blink_cnt + 8'h01;
            end else begin
                next_blink_mul = blink_mul + 8'h01;
            end
        end else begin
            next_blink_div = blink_div + 12'h001;
        end
    end

    // Timebase flops
    always_ff @(posedge clk) begin
        if (rst) begin
            ind_div <= 8'h00;
            ind_cnt <= 8'h00;
            dim_div <= 16'h0000;
            dim_cnt <= 4'h0;
            blink_div <= 12'h000;
            blink_mul <= 8'h00;
            blink_cnt <= 8'h00;
        end else begin
            ind_div <= next_ind_div;
            ind_cnt <= next_ind_cnt;
            dim_div <= next_dim_div;
            dim_cnt <= next_dim_cnt;
            blink_div <= next_blink_div;
            blink_mul <= next_blink_mul;
            blink_cnt <= next_blink_cnt;
        end
    end

    // Shared group signal: dimmer or blinker, never both
    always_comb begin
        // [RQ4] One group source for all channels
        if (!dim_blink_select) begin
            // [RQ20] Period code unused while dimming
            group_active = ({4'h0, dim_cnt} < {4'h0, group_duty[7:4]});
        end else if (group_period <= ledpwm_pkg::FAST_BLINK_MAX_CODE) begin
            // [RQ7] Fast blink 64-step duty
            group_active = duty_hit(blink_cnt, {group_duty[7:2], 2'h0});
        end else begin
            // [RQ8] Slow blink 256-step duty
            // [RQ21] Full code over 256
            group_active = duty_hit(blink_cnt, group_duty);
        end
    end

    // Per-channel state and transistor mapping
    always_comb begin
        logic on_level;
        logic lower_on;
        logic upper_on;
        on_level = 1'b0;
        lower_on = 1'b0;
        upper_on = 1'b0;
        for (int i = 0; i < 4; i++) begin
            // [RQ18] Decode the channel state field
            case (led_state_select[2*i +: 2])
                ledpwm_pkg::ST_OFF: on_level = 1'b0;
                ledpwm_pkg::ST_ON: on_level = 1'b1;
                // [RQ5] Individual PWM only
                ledpwm_pkg::ST_INDIV: on_level = duty_hit(ind_cnt, channel_duty[i]);
                // [RQ22] Individual AND group
                ledpwm_pkg::ST_GROUP: begin
                    if (!dim_blink_select) begin
                        // [RQ6] 64 steps at 6.25 kHz under the dimmer
                        on_level = duty_hit({2'h0, ind_cnt[5:0]}, {2'h0, channel_duty[i][7:2]}) && group_active;
                    end else begin
                        on_level = duty_hit(ind_cnt, channel_duty[i]) && group_active;
                    end
                end
                default: on_level = 1'b0;
            endcase
            // [RQ9] Invert complements the active level
            // [RQ11] Off: lower on only when inverted
            // [RQ12] On: lower on only when not inverted
            lower_on = on_level ^ output_invert;
            // [RQ10] Open-drain never sources
            // [RQ13] Drive zero switches the lower device
            // [RQ14] Totem-pole drives complementarily
            upper_on = output_drive_type && !lower_on;
            next_led_output_pin[i] = upper_on;
            next_led_output_pin_oe_n[i] = !(lower_on || upper_on);
        end
    end

    // Output pin flops; released (high-Z) during reset
    always_ff @(posedge clk) begin
        if (rst) begin
            led_output_pin <= 4'h0;
            led_output_pin_oe_n <= 4'hF;
        end else begin
            led_output_pin <= next_led_output_pin;
            led_output_pin_oe_n <= next_led_output_pin_oe_n;
        end
    end

endmodule : ledpwm_top

`default_nettype wire

// ---- ledpwm_led_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module ledpwm_led_model (
    // Pins as driven by the block
    input wire logic [3:0] pin,
    input wire logic [3:0] oe_n,
    // Level seen at each LED cathode
    output logic [3:0] lvl
);
    // LED to supply
    // A released pin is pulled up through the LED and its resistor
    assign lvl = oe_n | pin;
endmodule : ledpwm_led_model
`default_nettype wire

// ---- ledpwm_top_checker.sv ----
`timescale 1ns/1ps
`default_nettype none
module ledpwm_top_checker (
    // Clock, reset and bus
    input wire logic clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // LED pins
    input wire logic [3:0] led_output_pin,
    input wire logic [3:0] led_output_pin_oe_n
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // Shadow of dim, invert, drive and channel states
    logic [10:0] cfg;
    logic [10:0] cfg_d1;
    logic [10:0] cfg_d2;
    logic [7:0] per;
    logic stab;
    logic low0;
    logic up0;
    // Two delayed copies cover the pin latency after a write
    assign stab = (cfg == cfg_d1) && (cfg_d1 == cfg_d2);
    assign low0 = (cfg[1:0] == 2'h1) ^ cfg[9];
    assign up0 = cfg[8] && !low0;
    // Writes land at the access edge, as in the block
    always_ff @(posedge clk) begin
        if (rst) begin
            cfg <= 11'h0;
            cfg_d1 <= 11'h0;
            cfg_d2 <= 11'h0;
            per <= 8'h0;
        end else begin
            cfg_d1 <= cfg;
            cfg_d2 <= cfg_d1;
            if (psel && penable && pwrite && paddr == 32'h4) cfg[10:8] <= pwdata[2:0];
            if (psel && penable && pwrite && paddr == 32'h20) cfg[7:0] <= pwdata[7:0];
            if (psel && penable && pwrite && paddr == 32'h1C) per <= pwdata[7:0];
        end
    end
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_bad;
        s_setup ##0 (paddr[1:0] != 2'h0 || paddr == 32'h38);
    endsequence
    property p_reset_hiz;
        $fell(rst) |-> led_output_pin_oe_n == 4'hF && led_output_pin == 4'h0;
    endproperty
    a_reset_hiz: assert property (p_reset_hiz) else $error("pins driven after reset");
    property p_open_drain;
        !cfg[8] && !cfg_d1[8] && !cfg_d2[8] |-> (~led_output_pin_oe_n & led_output_pin) == 4'h0;
    endproperty
    a_open_drain: assert property (p_open_drain) else $error("upper driver on in open drain");
    property p_static_map;
        stab && !cfg[1] |-> led_output_pin_oe_n[0] == !(low0 || up0) && (led_output_pin_oe_n[0] || led_output_pin[0] == up0);
    endproperty
    a_static_map: assert property (p_static_map) else $error("static pin mapping wrong");
    property p_totem;
        stab && cfg[8] && cfg[1] |-> !led_output_pin_oe_n[0];
    endproperty
    a_totem: assert property (p_totem) else $error("totem pole pin released");
    property p_period_rb;
        s_setup ##0 (!pwrite && paddr == 32'h1C) |=> prdata == {24'h0, per};
    endproperty
    a_period_rb: assert property (p_period_rb) else $error("period code readback wrong");
    property p_mode_rb;
        s_setup ##0 (!pwrite && paddr == 32'h4) |=> prdata == {29'h0, cfg[10:8]};
    endproperty
    a_mode_rb: assert property (p_mode_rb) else $error("mode readback wrong");
    property p_status;
        s_setup ##0 (!pwrite && paddr == 32'h34) |=> prdata == {24'h0, $past(led_output_pin_oe_n), $past(led_output_pin)};
    endproperty
    a_status: assert property (p_status) else $error("status readback wrong");
    property p_err;
        s_bad |=> pslverr && prdata == 32'h0 && pready;
    endproperty
    a_err: assert property (p_err) else $error("bad access not refused");
    property p_ok;
        s_setup ##0 (paddr inside {32'h4, 32'h1C, 32'h20, 32'h34}) |=> !pslverr && pready;
    endproperty
    a_ok: assert property (p_ok) else $error("mapped access refused");
endmodule : ledpwm_top_checker
bind ledpwm_top ledpwm_top_checker u_ledpwm_top_checker (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .led_output_pin(led_output_pin), .led_output_pin_oe_n(led_output_pin_oe_n));
`default_nettype wire

// ---- ledpwm_top_tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module ledpwm_top_tb_top;
    // Bench drive, all set at time zero
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] paddr = 32'h0;
    logic [31:0] pwdata = 32'h0;
    wire logic [31:0] prdata;
    wire logic pready;
    wire logic pslverr;
    wire logic [3:0] pin;
    wire logic [3:0] oe_n;
    wire logic [3:0] lvl;
    int n_fail = 0;
    int check_count = 0;
    int cl [4];
    int cu [4];
    logic [31:0] rd;
    logic err;
    logic [7:0] dt [4] = '{8'h00, 8'h01, 8'h80, 8'hFF};
    // Short dimmer step keeps the dimming run brief
    ledpwm_top #(.DIM_TICK(4)) u_ledpwm_top (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .led_output_pin(pin), .led_output_pin_oe_n(oe_n));
    ledpwm_led_model u_ledpwm_led_model (.pin(pin), .oe_n(oe_n), .lvl(lvl));
    initial forever #25 clk = ~clk;
    task automatic end_of_test();
        if (n_fail == 0 && check_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : end_of_test
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    function automatic logic [31:0] ad(input logic [7:0] i);
        return {22'h0, i, 2'h0};
    endfunction : ad
    // One APB transfer; waits for pready with no bound of its own
    task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        // Only the watchdog ends a wait that never sees pready
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic cfg(input logic [2:0] m, input logic [7:0] s);
        apb(1'b1, ad(ledpwm_pkg::IDX_MODE_CONFIG_TWO), {29'h0, m});
        apb(1'b1, ad(ledpwm_pkg::IDX_LED_STATE_SELECT), {24'h0, s});
        repeat (3) @(posedge clk);
    endtask : cfg
    // Counts low-driven and high-driven cycles per pin
    task automatic count(input int n);
        for (int i = 0; i < 4; i++) begin
            cl[i] = 0;
            cu[i] = 0;
        end
        repeat (n) begin
            @(negedge clk);
            for (int i = 0; i < 4; i++) begin
                cl[i] += (oe_n[i] === 1'b0 && lvl[i] === 1'b0);
                cu[i] += (oe_n[i] === 1'b0 && lvl[i] === 1'b1);
            end
        end
    endtask : count
    task automatic t_defaults();
        for (int i = 1; i < 9; i++) begin
            apb(1'b0, ad(8'(i)), 32'h0);
            chk(rd, 32'h0);
        end
        apb(1'b0, ad(ledpwm_pkg::IDX_OUTPUT_STATUS), 32'h0);
        chk(rd, 32'hF0);
        apb(1'b1, ad(8'h0E), 32'hFF);
        chk({31'h0, err}, 32'h1);
        apb(1'b0, 32'h21, 32'h0);
        chk({31'h0, err}, 32'h1);
        apb(1'b1, ad(ledpwm_pkg::IDX_MODE_CONFIG_TWO), 32'hFF);
        apb(1'b0, ad(ledpwm_pkg::IDX_MODE_CONFIG_TWO), 32'h0);
        chk(rd, 32'h7);
    endtask : t_defaults
    // Off and on states under every invert and drive pair
    task automatic t_static();
        logic lo;
        for (int k = 0; k < 8; k++) begin
            cfg({1'b0, 2'(k)}, k[2] ? 8'h55 : 8'h00);
            @(negedge clk);
            lo = k[2] ^ k[1];
            chk({28'h0, oe_n}, (lo || k[0]) ? 32'h0 : 32'hF);
            chk({28'h0, lvl}, lo ? 32'h0 : 32'hF);
        end
    endtask : t_static
    // Individual PWM, group settings present but unused
    task automatic t_pwm(input logic [1:0] m);
        int e;
        for (int i = 0; i < 4; i++) apb(1'b1, ad(ledpwm_pkg::IDX_CHANNEL_DUTY0 + 8'(i)), {24'h0, dt[i]});
        cfg({1'b1, m}, 8'hAA);
        count(12800);
        for (int i = 0; i < 4; i++) begin
            e = m[1] ? (256 - dt[i]) * 50 : dt[i] * 50;
            chk(cl[i], e);
            chk(cu[i], m[0] ? 12800 - e : 0);
        end
    endtask : t_pwm
    // 6.25 kHz window of 3200 cycles holds 50 whole dimmer periods
    task automatic t_dim();
        logic [7:0] g [3] = '{8'h80, 8'hF0, 8'h00};
        for (int i = 0; i < 4; i++) apb(1'b1, ad(ledpwm_pkg::IDX_CHANNEL_DUTY0 + 8'(i)), 32'h80);
        apb(1'b1, ad(ledpwm_pkg::IDX_GROUP_PERIOD), 32'hFF);
        cfg(3'h0, 8'hFF);
        for (int j = 0; j < 3; j++) begin
            apb(1'b1, ad(ledpwm_pkg::IDX_GROUP_DUTY), {24'h0, g[j]});
            // Pins follow a register write one edge late
            repeat (2) @(posedge clk);
            count(3200);
            for (int i = 0; i < 4; i++) chk(cl[i], 100 * g[j][7:4]);
        end
    endtask : t_dim
    // Fresh reset aligns the blink phase to its first steps
    task automatic t_blink();
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        for (int i = 0; i < 4; i++) apb(1'b1, ad(ledpwm_pkg::IDX_CHANNEL_DUTY0 + 8'(i)), 32'hFF);
        apb(1'b1, ad(ledpwm_pkg::IDX_GROUP_DUTY), 32'h03);
        apb(1'b1, ad(ledpwm_pkg::IDX_GROUP_PERIOD), 32'h04);
        cfg(3'h4, 8'hFF);
        count(12800);
        for (int i = 0; i < 4; i++) chk(cl[i], 12750);
        apb(1'b1, ad(ledpwm_pkg::IDX_GROUP_PERIOD), 32'h03);
        repeat (3) @(posedge clk);
        count(400);
        for (int i = 0; i < 4; i++) chk(cl[i], 0);
    endtask : t_blink
    initial begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        t_defaults();
        t_static();
        t_pwm(2'h0);
        t_pwm(2'h1);
        t_pwm(2'h3);
        t_dim();
        t_blink();
        end_of_test();
    end
    initial begin
        #(90000 * 50);
        n_fail++;
        end_of_test();
    end
endmodule : ledpwm_top_tb_top
`default_nettype wire
